// ===== rtl/link_cfg_pkg.sv
// Constants for the serial link configuration register bank
package link_cfg_pkg;

  // Register indices and byte addresses (index times four)
  localparam logic [9:0]  IDX_REALIGN   = 10'h0A0;
  localparam logic [9:0]  IDX_TERM      = 10'h0A1;
  localparam logic [9:0]  IDX_LINK_EN   = 10'h100;
  localparam logic [9:0]  IDX_MODE      = 10'h101;
  localparam logic [9:0]  IDX_STREAMS   = 10'h102;
  localparam logic [9:0]  IDX_CONTROL   = 10'h103;
  localparam logic [9:0]  IDX_STATUS    = 10'h110;
  localparam logic [9:0]  IDX_VIOLATION = 10'h111;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_REALIGN   = {IDX_REALIGN, 2'b00};
  localparam logic [11:0] ADDR_TERM      = {IDX_TERM, 2'b00};
  localparam logic [11:0] ADDR_LINK_EN   = {IDX_LINK_EN, 2'b00};
  localparam logic [11:0] ADDR_MODE      = {IDX_MODE, 2'b00};
  localparam logic [11:0] ADDR_STREAMS   = {IDX_STREAMS, 2'b00};
  localparam logic [11:0] ADDR_CONTROL   = {IDX_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_VIOLATION = {IDX_VIOLATION, 2'b00};

  // Reset values
  localparam logic [7:0] RST_REALIGN = 8'h00;
  localparam logic [7:0] RST_TERM    = 8'h00;
  localparam logic [7:0] RST_LINK_EN = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_STREAMS = 8'h01;
  localparam logic [7:0] RST_CONTROL = 8'h03;

  // Field positions
  localparam int BIT_ENABLE    = 0;
  localparam int MODE_MSB      = 5;
  localparam int STREAMS_MSB   = 3;
  localparam int VIO_MODE      = 0;
  localparam int VIO_STREAMS   = 1;
  localparam int VIO_CONTROL   = 2;
  localparam int VIO_LINK_EN   = 3;

  // Last multiframe counter value; the period is 32 clock cycles
  localparam logic [7:0] LMFC_LAST = 8'h1F;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== rtl/lane_calc_if.sv
// Carrier between the register bank and the lane count calculator
`timescale 1ns/1ps
`default_nettype none
interface lane_calc_if;
  logic [3:0] streams;
  logic [4:0] stream_max;
  logic [4:0] lane_base;
  logic [7:0] lanes;
  modport owner (output streams, stream_max, lane_base, input lanes);
  modport calc  (input streams, stream_max, lane_base, output lanes);
endinterface
`default_nettype wire

// ===== rtl/lane_calc.sv
// Lane count: low eight bits of ceiling of streams times lane base over stream maximum
`timescale 1ns/1ps
`default_nettype none
module lane_calc (
  lane_calc_if.calc bus
);

  logic [8:0] total;
  logic [8:0] divisor;
  logic [8:0] whole;
  logic [8:0] part;

  // Product fits nine bits: 15 streams times base 31 at most
  assign total   = {5'h00, bus.streams} * {4'h0, bus.lane_base};
  assign divisor = {4'h0, bus.stream_max};
  assign whole   = total / divisor;
  assign part    = total % divisor;

  // Zero stream maximum gives zero lanes rather than a bogus count
  always_comb begin
    if (bus.stream_max == 5'h00) begin
      bus.lanes = 8'h00;
    end else begin
      bus.lanes = 8'(whole + {8'h00, part != 9'h000});
    end
  end

endmodule
`default_nettype wire

// ===== rtl/serial_link_config_regs.sv
// Serial link configuration register bank with AXI4-Lite slave
//
// Summary of operation
// - With realign enabled, every detected reference edge realigns timing.
// - A realignment acts on the clock divider, and on the link logic only while link enable is 1.
// - Link enable at 0 holds the link in reset and the PHY disabled.
// - Link enable at 0 holds the multiframe counter so edges cannot align it.
// - The interface mode is a six-bit read/write field resetting to zero.
// - The stream count is a four-bit read/write field resetting to one.
// - While link enable is 1, lanes enabled equal the low eight bits of ceiling of streams times base over stream max.
// - A stored bit picks differential (0) or single-ended (1) termination.
`timescale 1ns/1ps
`default_nettype none
module serial_link_config_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Device state inputs
  input  wire logic        datapath_enable,
  input  wire logic        sysref_edge,
  input  wire logic [4:0]  mode_stream_max,
  input  wire logic [4:0]  mode_lane_base,
  // Timing alignment outputs
  output logic             divider_realign,
  output logic             link_realign,
  output logic [7:0]       lmfc_phase,
  output logic             lmfc_tick,
  // Link configuration outputs
  output logic             link_reset,
  output logic             phy_enable,
  output logic             ref_term_single_ended_sel,
  output logic [5:0]       link_mode_select,
  output logic [3:0]       stream_count,
  output logic [7:0]       link_control,
  output logic [7:0]       lane_count
);

  // Stored register images, reserved bits included
  logic [7:0]  edge_realign_control_reg;
  logic [7:0]  ref_termination_config_reg;
  logic [7:0]  link_subsystem_enable_reg;
  logic [7:0]  link_mode_select_reg;
  logic [7:0]  stream_count_reg;
  logic [7:0]  link_control_reg;
  logic [3:0]  violation_reg;
  logic [3:0]  violation_next;

  // Write channel holding state
  logic [11:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0]  wr_strb_reg;
  logic        aw_take;
  logic        w_take;
  logic        do_write;
  logic        wr_lane0;
  logic [7:0]  wr_byte;

  // Read path
  logic        ar_take;
  logic [31:0] rd_word;
  logic        rd_hit;

  // Timing
  logic        edge_realign_enable;
  logic        link_on;
  logic        realign_now;
  logic [7:0]  lmfc_count_reg;

  lane_calc_if calc_bus ();

  assign edge_realign_enable = edge_realign_control_reg[link_cfg_pkg::BIT_ENABLE];
  assign link_on  = link_subsystem_enable_reg[link_cfg_pkg::BIT_ENABLE];
  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  // Both halves held and no response outstanding
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_lane0 = do_write && wr_strb_reg[0];
  assign wr_byte  = wr_data_reg[7:0];

  // ---------------- AXI write channels ----------------

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      wr_addr_reg   <= 12'h000;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      wr_addr_reg   <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_wready <= 1'b1;
      wr_data_reg  <= 32'h0000_0000;
      wr_strb_reg  <= 4'h0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      wr_data_reg  <= s_axi_wdata;
      wr_strb_reg  <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= link_cfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (wr_addr_reg)
        link_cfg_pkg::ADDR_REALIGN,
        link_cfg_pkg::ADDR_TERM,
        link_cfg_pkg::ADDR_LINK_EN,
        link_cfg_pkg::ADDR_MODE,
        link_cfg_pkg::ADDR_STREAMS,
        link_cfg_pkg::ADDR_CONTROL,
        link_cfg_pkg::ADDR_STATUS,
        link_cfg_pkg::ADDR_VIOLATION: begin
          s_axi_bresp <= link_cfg_pkg::RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= link_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- Register storage ----------------
  // Full bytes are kept so reserved bits read back as written

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_realign_control_reg <= link_cfg_pkg::RST_REALIGN;
    end else if (wr_lane0 && wr_addr_reg == link_cfg_pkg::ADDR_REALIGN) begin
      edge_realign_control_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_termination_config_reg <= link_cfg_pkg::RST_TERM;
    end else if (wr_lane0 && wr_addr_reg == link_cfg_pkg::ADDR_TERM) begin
      ref_termination_config_reg <= wr_byte;
    end
  end

  // No interlock in hardware: software sequencing is trusted and audited
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_subsystem_enable_reg <= link_cfg_pkg::RST_LINK_EN;
    end else if (wr_lane0 && wr_addr_reg == link_cfg_pkg::ADDR_LINK_EN) begin
      link_subsystem_enable_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_mode_select_reg <= link_cfg_pkg::RST_MODE;
    end else if (wr_lane0 && wr_addr_reg == link_cfg_pkg::ADDR_MODE) begin
      link_mode_select_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stream_count_reg <= link_cfg_pkg::RST_STREAMS;
    end else if (wr_lane0 && wr_addr_reg == link_cfg_pkg::ADDR_STREAMS) begin
      stream_count_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_control_reg <= link_cfg_pkg::RST_CONTROL;
    end else if (wr_lane0 && wr_addr_reg == link_cfg_pkg::ADDR_CONTROL) begin
      link_control_reg <= wr_byte;
    end
  end

  // ---------------- Sequencing violation flags ----------------
  // Sticky, write one to clear; a new violation wins over the clear

  always_comb begin
    violation_next = violation_reg;
    if (wr_lane0 && wr_addr_reg == link_cfg_pkg::ADDR_VIOLATION) begin
      violation_next = violation_reg & ~wr_byte[3:0];
    end
    if (wr_lane0 && link_on) begin
      if (wr_addr_reg == link_cfg_pkg::ADDR_MODE) begin
        violation_next[link_cfg_pkg::VIO_MODE] = 1'b1;
      end
      if (wr_addr_reg == link_cfg_pkg::ADDR_CONTROL) begin
        violation_next[link_cfg_pkg::VIO_CONTROL] = 1'b1;
      end
    end
    if (wr_lane0 && (link_on || datapath_enable)
        && wr_addr_reg == link_cfg_pkg::ADDR_STREAMS) begin
      violation_next[link_cfg_pkg::VIO_STREAMS] = 1'b1;
    end
    if (wr_lane0 && datapath_enable
        && wr_addr_reg == link_cfg_pkg::ADDR_LINK_EN) begin
      violation_next[link_cfg_pkg::VIO_LINK_EN] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      violation_reg <= 4'h0;
    end else begin
      violation_reg <= violation_next;
    end
  end

  // ---------------- AXI read channel ----------------

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      link_cfg_pkg::ADDR_REALIGN: begin
        rd_word[7:0] = edge_realign_control_reg;
      end
      link_cfg_pkg::ADDR_TERM: begin
        rd_word[7:0] = ref_termination_config_reg;
      end
      link_cfg_pkg::ADDR_LINK_EN: begin
        rd_word[7:0] = link_subsystem_enable_reg;
      end
      link_cfg_pkg::ADDR_MODE: begin
        rd_word[7:0] = link_mode_select_reg;
      end
      link_cfg_pkg::ADDR_STREAMS: begin
        rd_word[7:0] = stream_count_reg;
      end
      link_cfg_pkg::ADDR_CONTROL: begin
        rd_word[7:0] = link_control_reg;
      end
      link_cfg_pkg::ADDR_STATUS: begin
        rd_word[0]    = link_on;
        rd_word[1]    = datapath_enable;
        rd_word[15:8] = lane_count;
        rd_word[23:16] = lmfc_count_reg;
      end
      link_cfg_pkg::ADDR_VIOLATION: begin
        rd_word[3:0] = violation_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= link_cfg_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? link_cfg_pkg::RESP_OKAY
                              : link_cfg_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ---------------- Realignment and multiframe counter ----------------

  assign realign_now = sysref_edge && edge_realign_enable;

  // Divider always follows; link side only when the link is running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divider_realign <= 1'b0;
      link_realign    <= 1'b0;
    end else begin
      divider_realign <= realign_now;
      link_realign    <= realign_now && link_on;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lmfc_count_reg <= 8'h00;
    end else if (!link_on) begin
      lmfc_count_reg <= 8'h00;
    end else if (realign_now) begin
      lmfc_count_reg <= 8'h00;
    end else if (lmfc_count_reg == link_cfg_pkg::LMFC_LAST) begin
      lmfc_count_reg <= 8'h00;
    end else begin
      lmfc_count_reg <= lmfc_count_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lmfc_phase <= 8'h00;
      lmfc_tick  <= 1'b0;
    end else begin
      lmfc_phase <= lmfc_count_reg;
      lmfc_tick  <= link_on && (lmfc_count_reg == 8'h00);
    end
  end

  // ---------------- Link control outputs ----------------

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_reset <= 1'b1;
      phy_enable <= 1'b0;
    end else begin
      link_reset <= !link_on;
      phy_enable <= link_on;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_term_single_ended_sel <= 1'b0;
      link_mode_select          <= 6'h00;
      stream_count              <= 4'h1;
      link_control              <= link_cfg_pkg::RST_CONTROL;
    end else begin
      ref_term_single_ended_sel <=
        ref_termination_config_reg[link_cfg_pkg::BIT_ENABLE];
      link_mode_select <= link_mode_select_reg[link_cfg_pkg::MODE_MSB:0];
      stream_count     <= stream_count_reg[link_cfg_pkg::STREAMS_MSB:0];
      link_control     <= link_control_reg;
    end
  end

  // ---------------- Lane count ----------------

  assign calc_bus.streams    = stream_count_reg[link_cfg_pkg::STREAMS_MSB:0];
  assign calc_bus.stream_max = mode_stream_max;
  assign calc_bus.lane_base  = mode_lane_base;

  lane_calc u_lane_calc (
    .bus (calc_bus)
  );

  // Lanes read zero while the link is held off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lane_count <= 8'h00;
    end else begin
      lane_count <= link_on ? calc_bus.lanes : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ===== bench/serial_link_config_regs_props.sv
// Port-level properties of the link configuration register bank
`timescale 1ns/1ps
`default_nettype none
module serial_link_config_regs_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Device side
  input wire logic        sysref_edge,
  input wire logic [4:0]  mode_stream_max,
  input wire logic [4:0]  mode_lane_base,
  input wire logic        divider_realign,
  input wire logic        link_realign,
  input wire logic [7:0]  lmfc_phase,
  input wire logic        lmfc_tick,
  input wire logic        link_reset,
  input wire logic        phy_enable,
  input wire logic [5:0]  link_mode_select,
  input wire logic [3:0]  stream_count,
  input wire logic [7:0]  link_control,
  input wire logic [7:0]  lane_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Zero stream maximum is masked so the divide never matters
  logic [9:0] lanes_exp;
  assign lanes_exp = (link_reset || mode_stream_max == 5'h00) ? 10'h000 :
    ({6'h00, stream_count} * {5'h00, mode_lane_base}
     + {5'h00, mode_stream_max} - 10'h001) / {5'h00, mode_stream_max};

  property p_realign_cause;
    divider_realign |-> $past(sysref_edge);
  endproperty
  a_realign_cause: assert property (p_realign_cause)
    else $error("divider realign without a reference edge");
  property p_realign_both;
    link_realign |-> divider_realign && phy_enable;
  endproperty
  a_realign_both: assert property (p_realign_both)
    else $error("link realign alone or with the link disabled");
  property p_reset_phy;
    link_reset |-> !phy_enable && !link_realign && lane_count == 8'h00;
  endproperty
  a_reset_phy: assert property (p_reset_phy)
    else $error("phy enabled while link held in reset");
  property p_lmfc_held;
    link_reset [*3] |-> lmfc_phase == 8'h00 && !lmfc_tick;
  endproperty
  a_lmfc_held: assert property (p_lmfc_held)
    else $error("multiframe counter moves while link disabled");
  property p_lmfc_tick;
    phy_enable |-> lmfc_tick == (lmfc_phase == 8'h00);
  endproperty
  a_lmfc_tick: assert property (p_lmfc_tick)
    else $error("multiframe tick out of step with the counter");
  property p_lane_count;
    ($stable(stream_count) && $stable(mode_stream_max) &&
     $stable(mode_lane_base) && $stable(link_reset)) [*3]
    |-> lane_count == lanes_exp[7:0];
  endproperty
  a_lane_count: assert property (p_lane_count)
    else $error("lane count differs from its formula");
  property p_reset_fields;
    $fell(reset) |-> stream_count == 4'h1 && link_mode_select == 6'h00
      && link_control == 8'h03 && link_reset;
  endproperty
  a_reset_fields: assert property (p_reset_fields)
    else $error("field outputs not at reset values");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped before taken");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data late");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data dropped before taken");
endmodule
`default_nettype wire

// ===== bench/tb_serial_link_config_regs.sv
// Directed bench for the link configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_serial_link_config_regs;
  logic        clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, datapath_enable, sysref_edge;
  logic        div_rl, link_rl, lmfc_tick, link_reset, phy_enable, term_se;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, streams;
  logic [1:0]  bresp, rresp;
  logic [4:0]  smax, lbase;
  logic [7:0]  lmfc_phase, link_control, lane_count;
  logic [5:0]  mode;
  int          failures, samples_checked, cycles, div_cnt, link_cnt;
  localparam logic [11:0] REG_ADDR [6] = '{link_cfg_pkg::ADDR_REALIGN,
    link_cfg_pkg::ADDR_TERM, link_cfg_pkg::ADDR_LINK_EN,
    link_cfg_pkg::ADDR_MODE, link_cfg_pkg::ADDR_STREAMS,
    link_cfg_pkg::ADDR_CONTROL};
  localparam logic [7:0] REG_RST [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h03};
  localparam int LANE_TAB [3][3] = '{'{1, 2, 1}, '{4, 8, 4}, '{6, 8, 4}};
  localparam logic [1:0] OK = link_cfg_pkg::RESP_OKAY;

  serial_link_config_regs i_dut (
    .clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .datapath_enable(datapath_enable), .sysref_edge(sysref_edge),
    .mode_stream_max(smax), .mode_lane_base(lbase),
    .divider_realign(div_rl), .link_realign(link_rl),
    .lmfc_phase(lmfc_phase), .lmfc_tick(lmfc_tick),
    .link_reset(link_reset), .phy_enable(phy_enable),
    .ref_term_single_ended_sel(term_se), .link_mode_select(mode),
    .stream_count(streams), .link_control(link_control),
    .lane_count(lane_count));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task print_verdict;
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Pulse counters, plus the hang limit (run needs well under 1000 cycles)
  always @(posedge clk) begin
    cycles++;
    if (div_rl === 1'b1) div_cnt++;
    if (link_rl === 1'b1) link_cnt++;
    if (cycles == 4000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, r}, "write resp");
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(rdata, {24'h000000, d}, "read data");
        chk({30'h0, rresp}, {30'h0, r}, "read resp");
      end
    end
  endtask

  // One reference edge, then time for the pulses to land
  task automatic pulse;
    @(posedge clk);
    sysref_edge <= 1'b1;
    @(posedge clk);
    sysref_edge <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {datapath_enable, sysref_edge} = 2'h0;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    smax = 5'h02;
    lbase = 5'h01;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(REG_ADDR[i], REG_RST[i], link_cfg_pkg::RESP_OKAY);
    end
    // Reserved bits all set, enables clear, legal stream count
    for (int i = 0; i < 6; i++) begin
      wr(REG_ADDR[i], (i == 4) ? 8'hF2 : 8'hFE, link_cfg_pkg::RESP_OKAY);
      rd(REG_ADDR[i], (i == 4) ? 8'hF2 : 8'hFE, link_cfg_pkg::RESP_OKAY);
    end
    repeat (2) @(posedge clk);
    chk({26'h0, mode}, 32'h3E, "mode pins");
    chk({28'h0, streams}, 32'h2, "stream pins");
    chk({24'h0, link_control}, 32'hFE, "control pins");
    chk({31'h0, term_se}, 32'h0, "termination");
    chk({31'h0, link_reset}, 32'h1, "link reset");
    pulse();
    chk(div_cnt, 0, "realign while disabled");
    wr(link_cfg_pkg::ADDR_REALIGN, 8'h01, link_cfg_pkg::RESP_OKAY);
    pulse();
    chk(div_cnt, 1, "divider realign");
    chk(link_cnt, 0, "link realign while link off");
    wr(link_cfg_pkg::ADDR_TERM, 8'h01, link_cfg_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, term_se}, 32'h1, "single-ended termination");
    wr(link_cfg_pkg::ADDR_TERM, 8'h00, link_cfg_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, term_se}, 32'h0, "differential termination");
    // Configure with the link off and datapath idle, then enable
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      smax <= 5'(LANE_TAB[i][1]);
      lbase <= 5'(LANE_TAB[i][2]);
      wr(link_cfg_pkg::ADDR_STREAMS, 8'(LANE_TAB[i][0]), OK);
      wr(link_cfg_pkg::ADDR_LINK_EN, 8'h01, OK);
      repeat (4) @(posedge clk);
      chk({24'h0, lane_count}, 32'((LANE_TAB[i][0] * LANE_TAB[i][2]
          + LANE_TAB[i][1] - 1) / LANE_TAB[i][1]), "lanes");
      chk({30'h0, phy_enable, link_reset}, 32'h2, "link live");
      pulse();
      chk(link_cnt, i + 1, "link realign");
      chk(div_cnt, i + 2, "divider realign with link");
      wr(link_cfg_pkg::ADDR_LINK_EN, 8'h00, link_cfg_pkg::RESP_OKAY);
      repeat (4) @(posedge clk);
      chk({30'h0, phy_enable, link_reset}, 32'h1, "link held");
      chk({23'h0, lmfc_tick, lmfc_phase}, 32'h0, "counter held");
      chk({24'h0, lane_count}, 32'h0, "lanes off");
    end
    // Deliberate writes with the link up must raise sticky flags
    wr(link_cfg_pkg::ADDR_LINK_EN, 8'h01, OK);
    wr(link_cfg_pkg::ADDR_MODE, 8'h3F, OK);
    wr(link_cfg_pkg::ADDR_CONTROL, 8'h03, OK);
    rd(link_cfg_pkg::ADDR_VIOLATION, 8'h05, OK);
    wr(link_cfg_pkg::ADDR_VIOLATION, 8'h0F, OK);
    rd(link_cfg_pkg::ADDR_VIOLATION, 8'h00, OK);
    wr(link_cfg_pkg::ADDR_LINK_EN, 8'h00, OK);
    pulse();
    chk(link_cnt, 3, "no link realign when off");
    wr(12'hFFC, 8'h5A, link_cfg_pkg::RESP_SLVERR);
    rd(12'hFFC, 8'h00, link_cfg_pkg::RESP_SLVERR);
    print_verdict();
  end
endmodule

bind serial_link_config_regs serial_link_config_regs_props i_props (
  .clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sysref_edge(sysref_edge),
  .mode_stream_max(mode_stream_max), .mode_lane_base(mode_lane_base),
  .divider_realign(divider_realign), .link_realign(link_realign),
  .lmfc_phase(lmfc_phase), .lmfc_tick(lmfc_tick),
  .link_reset(link_reset), .phy_enable(phy_enable),
  .link_mode_select(link_mode_select), .stream_count(stream_count),
  .link_control(link_control), .lane_count(lane_count));
`default_nettype wire
